/* File: rtl/gtc_prescaler.v */
// Prescale counter dividing source ticks by 1, 2, 4 or 8
`timescale 1ns/1ps
`include "gtc_regs.vh"

module gtc_prescaler (
    input wire mclk,
    input wire reset,
    input wire clear,
    input wire tick_in,
    input wire [1:0] ratio_sel,
    output wire tick_out
);
    reg [2:0] pre_r;
    reg [2:0] pre_nxt;
    reg [2:0] last;

    always @* begin
        case (ratio_sel)
            `GTC_PS_DIV1: last = `GTC_PRE_LAST1;
            `GTC_PS_DIV2: last = `GTC_PRE_LAST2;
            `GTC_PS_DIV4: last = `GTC_PRE_LAST4;
            default: last = `GTC_PRE_LAST8;
        endcase
    end

    // Counter is hidden from software and cleared by count writes
    assign tick_out = tick_in && !clear && (pre_r == last); // [RQ10]

    always @* begin
        pre_nxt = pre_r;
        if (clear) begin
            pre_nxt = `GTC_PRE_ZERO; // [RQ11]
        end else if (tick_in) begin
            if (pre_r == last) begin
                pre_nxt = `GTC_PRE_ZERO;
            end else begin
                pre_nxt = pre_r + `GTC_PRE_ONE; // [RQ10]
            end
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            pre_r <= `GTC_PRE_ZERO;
        end else begin
            pre_r <= pre_nxt;
        end
    end
endmodule

/* File: rtl/gtc_regs.vh */
// Register offsets, field positions and constants of the gated timer/counter
`ifndef GTC_REGS_VH
`define GTC_REGS_VH

`define GTC_ADDR_W 3
`define GTC_A_COUNT_LOW 3'h0
`define GTC_A_COUNT_HIGH 3'h1
`define GTC_A_TIMER_CTRL 3'h2
`define GTC_A_GATE_CTRL 3'h3
`define GTC_A_INT_STATUS 3'h4
`define GTC_A_INT_MASK 3'h5

// timer_control_reg fields
`define GTC_CS_HI 7
`define GTC_CS_LO 6
`define GTC_PS_HI 5
`define GTC_PS_LO 4
`define GTC_OSCEN_BIT 3
`define GTC_SYNCDIS_BIT 2
`define GTC_RUN_BIT 0
`define GTC_TCTRL_MASK 8'hfd

// gate_control_reg fields
`define GTC_GATE_EN_BIT 7
`define GTC_GATE_POL_BIT 6
`define GTC_GCTRL_MASK 8'hc0

// Status and mask fields
`define GTC_ST_OVF_BIT 0
`define GTC_ST_WAKE_BIT 1
`define GTC_ST_MASK 8'h03

// Clock select codes
`define GTC_CS_INSTR 2'h0
`define GTC_CS_SYSCLK 2'h1
`define GTC_CS_EXT 2'h2
`define GTC_CS_CAPOSC 2'h3

// Prescale codes
`define GTC_PS_DIV1 2'h0
`define GTC_PS_DIV2 2'h1
`define GTC_PS_DIV4 2'h2
`define GTC_PS_DIV8 2'h3

// Instruction cycle is four system clocks
`define GTC_INSTR_LAST 2'h3

`define GTC_BYTE_ZERO 8'h00
`define GTC_COUNT_ZERO 16'h0000
`define GTC_COUNT_ALL1 16'hffff
`define GTC_COUNT_ONE 16'h0001
`define GTC_PRE_ZERO 3'h0
`define GTC_PRE_ONE 3'h1
`define GTC_PRE_LAST1 3'h0
`define GTC_PRE_LAST2 3'h1
`define GTC_PRE_LAST4 3'h3
`define GTC_PRE_LAST8 3'h7

`endif

/* File: rtl/gtc_timer.v */
// Gated sixteen-bit timer/counter with register port and overflow interrupt
// Functional notes
// (RQ1) The count is a 16-bit up-counter seen by software as a high and a low byte.
// (RQ2) Writing either count byte replaces that byte of the live count at once.
// (RQ3) With the instruction clock chosen the count advances once per instruction cycle.
// (RQ4) With an internal source the count steps at multiples of the system clock period.
// (RQ5) With an external source the count steps on rising edges of the pin or oscillator.
// (RQ6) External sources run either resynchronised or without resynchronisation.
// (RQ7) Run bit clear stops the timer; run set with gate enable clear always counts.
// (RQ8) The clock select field and oscillator enable choose the count source.
// (RQ9) In counter mode a falling edge must be seen before the first counted rising edge.
// (RQ10) The prescale field divides the chosen source by 1, 2, 4 or 8.
// (RQ11) The prescale counter is hidden and is cleared by any count byte write.
// (RQ12) Overflow raises an interrupt and in asynchronous external mode can wake the core.
// (RQ13) The sync disable bit makes the external input skip resynchronisation.
// (RQ14) In gated mode the count advances only while the gate is active, else it holds.
// (RQ15) The overflow flag sets on the wrap from all ones to zero and stays until cleared.
`timescale 1ns/1ps
`include "gtc_regs.vh"

module gtc_timer (
    input wire mclk,
    input wire reset,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire external_count_pin,
    input wire cap_osc_in,
    input wire crystal_input_pin,
    output reg crystal_output_pin,
    input wire gate_input,
    input wire sleep_mode,
    output reg irq,
    output reg wake
);
    localparam ST_IDLE = 2'b01;
    localparam ST_ARMED = 2'b10;

    reg [15:0] count_r;
    reg [15:0] count_nxt;
    reg [7:0] timer_control_reg;
    reg [7:0] gate_control_reg;
    reg [7:0] int_status_r;
    reg [7:0] int_status_nxt;
    reg [7:0] int_mask_r;
    reg [1:0] instr_phase_r;
    reg ext_sync1_r;
    reg ext_sync2_r;
    reg ext_prev_r;
    reg [1:0] arm_state_r;
    reg [1:0] arm_state_nxt;
    reg run_prev_r;

    wire [1:0] clock_select_field;
    wire [1:0] prescale_select_field;
    wire crystal_osc_enable;
    wire sync_disable_bit;
    wire run_bit;
    wire gate_enable_bit;
    wire gate_polarity_bit;
    wire ext_raw;
    wire ext_level;
    wire ext_rise;
    wire ext_fall;
    wire is_external;
    wire count_write;
    wire gate_open;
    wire count_enable;
    wire src_tick;
    wire pre_tick;
    wire inc;
    wire overflow;
    wire wake_event;

    // Decodes whether a write or read hits a given register
    function hit;
        input [2:0] addr;
        input [2:0] target;
        input strobe;
        begin
            hit = strobe && (addr == target);
        end
    endfunction

    assign clock_select_field = timer_control_reg[`GTC_CS_HI:`GTC_CS_LO];
    assign prescale_select_field = timer_control_reg[`GTC_PS_HI:`GTC_PS_LO];
    assign crystal_osc_enable = timer_control_reg[`GTC_OSCEN_BIT];
    assign sync_disable_bit = timer_control_reg[`GTC_SYNCDIS_BIT];
    assign run_bit = timer_control_reg[`GTC_RUN_BIT];
    assign gate_enable_bit = gate_control_reg[`GTC_GATE_EN_BIT];
    assign gate_polarity_bit = gate_control_reg[`GTC_GATE_POL_BIT];

    // External source choice: pin, crystal circuit or capacitive oscillator
    assign ext_raw = (clock_select_field == `GTC_CS_CAPOSC) ? cap_osc_in :
        (crystal_osc_enable ? crystal_input_pin : external_count_pin); // [RQ8]
    assign is_external = clock_select_field[1];

    // Bypass trades metastability margin for counting while the core sleeps
    assign ext_level = sync_disable_bit ? ext_raw : ext_sync2_r; // [RQ6] [RQ13]
    assign ext_rise = ext_level && !ext_prev_r;
    assign ext_fall = !ext_level && ext_prev_r;

    assign count_write = hit(reg_addr, `GTC_A_COUNT_LOW, reg_wr) ||
        hit(reg_addr, `GTC_A_COUNT_HIGH, reg_wr);

    // Gate active level follows the polarity bit
    assign gate_open = (gate_input == gate_polarity_bit); // [RQ14]
    assign count_enable = run_bit && (!gate_enable_bit || gate_open); // [RQ7] [RQ14]

    always @* begin
        arm_state_nxt = arm_state_r;
        case (arm_state_r)
            ST_IDLE: begin
                if (ext_fall) begin
                    arm_state_nxt = ST_ARMED; // [RQ9]
                end
            end
            ST_ARMED: begin
                arm_state_nxt = ST_ARMED;
            end
            default: begin
                arm_state_nxt = ST_IDLE;
            end
        endcase
        // Enable, count write or disable each demand a fresh falling edge
        if (count_write || !run_bit || (run_bit && !run_prev_r)) begin
            arm_state_nxt = ST_IDLE; // [RQ9]
        end
    end

    assign src_tick = (clock_select_field == `GTC_CS_SYSCLK) ? 1'b1 : // [RQ4] [RQ8]
        (clock_select_field == `GTC_CS_INSTR) ? (instr_phase_r == `GTC_INSTR_LAST) : // [RQ3]
        (ext_rise && (arm_state_r == ST_ARMED)); // [RQ5] [RQ9]

    gtc_prescaler u_pre (
        .mclk(mclk),
        .reset(reset),
        .clear(count_write),
        .tick_in(src_tick && count_enable),
        .ratio_sel(prescale_select_field),
        .tick_out(pre_tick)
    );

    // A count write takes the cycle; no increment collides with it
    assign inc = pre_tick && count_enable && !count_write;
    assign overflow = inc && (count_r == `GTC_COUNT_ALL1); // [RQ15]
    // Wake only when an unsynchronised external source keeps counting in sleep
    assign wake_event = overflow && is_external && sync_disable_bit && sleep_mode; // [RQ12]

    always @* begin
        count_nxt = count_r;
        if (hit(reg_addr, `GTC_A_COUNT_LOW, reg_wr)) begin
            count_nxt = {count_r[15:8], reg_wdata}; // [RQ2]
        end else if (hit(reg_addr, `GTC_A_COUNT_HIGH, reg_wr)) begin
            count_nxt = {reg_wdata, count_r[7:0]}; // [RQ2]
        end else if (inc) begin
            count_nxt = count_r + `GTC_COUNT_ONE; // [RQ1]
        end
    end

    always @* begin
        int_status_nxt = int_status_r;
        if (hit(reg_addr, `GTC_A_INT_STATUS, reg_rd)) begin
            int_status_nxt = `GTC_BYTE_ZERO;
        end
        // Set wins over the read clear
        if (overflow) begin
            int_status_nxt[`GTC_ST_OVF_BIT] = 1'b1; // [RQ12] [RQ15]
        end
        if (wake_event) begin
            int_status_nxt[`GTC_ST_WAKE_BIT] = 1'b1; // [RQ12]
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            instr_phase_r <= 2'h0;
            ext_sync1_r <= 1'b0;
            ext_sync2_r <= 1'b0;
            ext_prev_r <= 1'b0;
            arm_state_r <= ST_IDLE;
            run_prev_r <= 1'b0;
        end else begin
            instr_phase_r <= instr_phase_r + 2'h1; // [RQ3]
            ext_sync1_r <= ext_raw; // [RQ6]
            ext_sync2_r <= ext_sync1_r;
            ext_prev_r <= ext_level;
            arm_state_r <= arm_state_nxt;
            run_prev_r <= run_bit;
        end
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            count_r <= `GTC_COUNT_ZERO;
            timer_control_reg <= `GTC_BYTE_ZERO;
            gate_control_reg <= `GTC_BYTE_ZERO;
            int_status_r <= `GTC_BYTE_ZERO;
            int_mask_r <= `GTC_BYTE_ZERO;
        end else begin
            count_r <= count_nxt;
            int_status_r <= int_status_nxt;
            if (hit(reg_addr, `GTC_A_TIMER_CTRL, reg_wr)) begin
                timer_control_reg <= reg_wdata & `GTC_TCTRL_MASK;
            end
            if (hit(reg_addr, `GTC_A_GATE_CTRL, reg_wr)) begin
                gate_control_reg <= reg_wdata & `GTC_GCTRL_MASK;
            end
            if (hit(reg_addr, `GTC_A_INT_MASK, reg_wr)) begin
                int_mask_r <= reg_wdata & `GTC_ST_MASK;
            end
        end
    end

    // Read data valid in the cycle after the strobe only
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            reg_rdata <= `GTC_BYTE_ZERO;
        end else if (reg_rd) begin
            case (reg_addr)
                `GTC_A_COUNT_LOW: reg_rdata <= count_r[7:0]; // [RQ1]
                `GTC_A_COUNT_HIGH: reg_rdata <= count_r[15:8]; // [RQ1]
                `GTC_A_TIMER_CTRL: reg_rdata <= timer_control_reg;
                `GTC_A_GATE_CTRL: reg_rdata <= gate_control_reg;
                `GTC_A_INT_STATUS: reg_rdata <= int_status_r;
                `GTC_A_INT_MASK: reg_rdata <= int_mask_r;
                default: reg_rdata <= `GTC_BYTE_ZERO;
            endcase
        end else begin
            reg_rdata <= `GTC_BYTE_ZERO;
        end
    end

    // Level outputs from flops; updated on the same edge as the status
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
            wake <= 1'b0;
            crystal_output_pin <= 1'b0;
        end else begin
            irq <= |(int_status_nxt & int_mask_r); // [RQ12]
            wake <= int_status_nxt[`GTC_ST_WAKE_BIT] && int_mask_r[`GTC_ST_WAKE_BIT];
            // Amplifier output is the inverted crystal input while enabled
            crystal_output_pin <= crystal_osc_enable && !crystal_input_pin;
        end
    end
endmodule

/* File: sim/gtc_count_src.sv */
// External count sources running at three distinct rates
`timescale 1ns/1ps
module gtc_count_src (
    input wire mclk,
    input wire reset,
    output wire ext_pin,
    output wire cap_osc,
    output wire xtal
);
    reg [4:0] phase_r;
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            phase_r <= 5'h00;
        end else begin
            phase_r <= phase_r + 5'h01;
        end
    end
    // Distinct rates so a wrong source select gives a wrong count
    assign ext_pin = phase_r[2];
    assign cap_osc = phase_r[3];
    assign xtal = phase_r[4];
endmodule

/* File: sim/gtc_timer_props.sv */
// Port checker for the gated timer/counter
`timescale 1ns/1ps
`include "gtc_regs.vh"
module gtc_timer_props (
    input wire mclk,
    input wire reset,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire crystal_input_pin,
    input wire crystal_output_pin,
    input wire irq,
    input wire wake
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    AST_UNMAPPED: assert property ($past(reg_rd && reg_addr > 3'h5) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    // Mask write reaches irq one edge later than a status read
    AST_IRQ_FALL: assert property ($fell(irq) |->
        $past(reg_rd && reg_addr == 3'h4) || $past(reg_wr && reg_addr == 3'h5, 2))
        else $error("irq dropped without status read or mask write");
    AST_WAKE_IRQ: assert property (wake |-> irq)
        else $error("wake without irq");
    AST_XTAL_OUT: assert property ($past(crystal_input_pin) |-> !crystal_output_pin)
        else $error("crystal output not inverted");
    AST_TCTRL_RB: assert property ((reg_wr && reg_addr == 3'h2) ##1
        (reg_rd && reg_addr == 3'h2) |=> reg_rdata == ($past(reg_wdata, 2) & `GTC_TCTRL_MASK))
        else $error("timer control readback wrong");
    AST_GCTRL_RB: assert property ((reg_wr && reg_addr == 3'h3) ##1
        (reg_rd && reg_addr == 3'h3) |=> reg_rdata == ($past(reg_wdata, 2) & `GTC_GCTRL_MASK))
        else $error("gate control readback wrong");
    AST_MASK_RB: assert property ((reg_wr && reg_addr == 3'h5) ##1
        (reg_rd && reg_addr == 3'h5) |=> reg_rdata == ($past(reg_wdata, 2) & `GTC_ST_MASK))
        else $error("mask readback wrong");
endmodule
bind gtc_timer gtc_timer_props u_gtc_timer_props (.mclk(mclk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .crystal_input_pin(crystal_input_pin),
    .crystal_output_pin(crystal_output_pin), .irq(irq), .wake(wake));

/* File: sim/gtc_timer_test.sv */
// Self-checking bench for the gated timer/counter
`timescale 1ns/1ps
`include "gtc_regs.vh"
module gtc_timer_test;
    logic mclk, reset, reg_wr, reg_rd, gate_input, sleep_mode;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, rdat, v0;
    wire [7:0] reg_rdata;
    wire ext_pin, cap_osc, xtal, crystal_output_pin, irq, wake;
    int num_errors = 0;
    int cmp_count = 0;
    logic [31:0] rows [0:15];
    logic [31:0] ovf [0:2];
    logic [15:0] rb [0:2];
    gtc_timer u_gtc_timer (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_count_pin(ext_pin), .cap_osc_in(cap_osc), .crystal_input_pin(xtal),
        .crystal_output_pin(crystal_output_pin), .gate_input(gate_input),
        .sleep_mode(sleep_mode), .irq(irq), .wake(wake));
    gtc_count_src u_gtc_count_src (.mclk(mclk), .reset(reset), .ext_pin(ext_pin),
        .cap_osc(cap_osc), .xtal(xtal));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Data sampled at the falling edge, clear of the update edge
    task bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge mclk);
        rdat = reg_rdata;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        wrap_up;
    end
    initial begin
        {reset, reg_wr, reg_rd, gate_input, sleep_mode} = 5'b10000;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        // tctrl, gctrl, gate level, count gain over 64 cycles
        rows = '{32'h41000040, 32'h51000020, 32'h61000010, 32'h71000008, 32'h01000010,
            32'h31000002, 32'h40000000, 32'h40800000, 32'h41800100, 32'h41800040,
            32'h41c00140, 32'h81000008, 32'h85000008, 32'ha1000002, 32'h89000002,
            32'hc1000004};
        ovf = '{32'h41000001, 32'h41010001, 32'h85030103};
        rb = '{16'h02fd, 16'h03c0, 16'h0503};
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, i[2:0], 8'h00);
            chk("reset read", 8'h00, rdat);
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            reg_wr <= 1'b1;
            reg_addr <= rb[i][10:8];
            reg_wdata <= 8'hff;
            @(posedge mclk);
            reg_wr <= 1'b0;
            reg_rd <= 1'b1;
            @(posedge mclk);
            reg_rd <= 1'b0;
            @(negedge mclk);
            chk("readback", rb[i][7:0], reg_rdata);
        end
        bus(1'b1, `GTC_A_TIMER_CTRL, 8'h00);
        bus(1'b1, `GTC_A_COUNT_LOW, 8'h34);
        bus(1'b1, `GTC_A_COUNT_HIGH, 8'h12);
        bus(1'b0, `GTC_A_COUNT_LOW, 8'h00);
        chk("count low", 8'h34, rdat);
        bus(1'b0, `GTC_A_COUNT_HIGH, 8'h00);
        chk("count high", 8'h12, rdat);
        for (int i = 0; i < 16; i++) begin
            bus(1'b1, `GTC_A_TIMER_CTRL, 8'h00);
            bus(1'b1, `GTC_A_COUNT_LOW, 8'h00);
            bus(1'b1, `GTC_A_GATE_CTRL, rows[i][23:16]);
            @(posedge mclk);
            gate_input <= rows[i][8];
            bus(1'b1, `GTC_A_TIMER_CTRL, rows[i][31:24]);
            repeat (16) @(posedge mclk);
            bus(1'b0, `GTC_A_COUNT_LOW, 8'h00);
            v0 = rdat;
            repeat (62) @(posedge mclk);
            bus(1'b0, `GTC_A_COUNT_LOW, 8'h00);
            v0 = rdat - v0;
            chk("gain", rows[i][7:0], v0);
        end
        for (int j = 0; j < 3; j++) begin
            bus(1'b1, `GTC_A_TIMER_CTRL, 8'h00);
            bus(1'b1, `GTC_A_COUNT_LOW, 8'hfe);
            bus(1'b1, `GTC_A_COUNT_HIGH, 8'hff);
            bus(1'b1, `GTC_A_INT_MASK, ovf[j][23:16]);
            @(posedge mclk);
            sleep_mode <= ovf[j][8];
            bus(1'b1, `GTC_A_TIMER_CTRL, ovf[j][31:24]);
            repeat (40) @(posedge mclk);
            @(negedge mclk);
            chk("irq", {7'h00, |(ovf[j][23:16] & ovf[j][7:0])}, {7'h00, irq});
            chk("wake", {7'h00, ovf[j][17] & ovf[j][1]}, {7'h00, wake});
            bus(1'b0, `GTC_A_INT_STATUS, 8'h00);
            chk("status", ovf[j][7:0], rdat);
            chk("irq cleared", 8'h00, {7'h00, irq});
        end
        // Mid-run reset realigns the source model, so edge timing is known
        @(posedge mclk);
        reset <= 1'b1;
        @(posedge mclk);
        reset <= 1'b0;
        // Unsynchronised pin rises before it falls; that rise must not count
        bus(1'b1, `GTC_A_TIMER_CTRL, 8'h85);
        repeat (7) @(posedge mclk);
        bus(1'b0, `GTC_A_COUNT_LOW, 8'h00);
        chk("no count before fall", 8'h00, rdat);
        repeat (4) @(posedge mclk);
        bus(1'b0, `GTC_A_COUNT_LOW, 8'h00);
        chk("count after fall", 8'h01, rdat);
        bus(1'b0, `GTC_A_INT_MASK, 8'h00);
        chk("mask after reset", 8'h00, rdat);
        // Count write restarts the divide-by-eight phase
        bus(1'b1, `GTC_A_TIMER_CTRL, 8'h71);
        bus(1'b1, `GTC_A_COUNT_LOW, 8'h00);
        repeat (6) @(posedge mclk);
        bus(1'b0, `GTC_A_COUNT_LOW, 8'h00);
        chk("prescale cleared", 8'h00, rdat);
        bus(1'b0, `GTC_A_COUNT_LOW, 8'h00);
        chk("prescale restart", 8'h01, rdat);
        bus(1'b1, `GTC_A_TIMER_CTRL, 8'h08);
        for (int k = 0; k < 2; k++) begin
            repeat (16) @(posedge mclk);
            @(negedge mclk);
            v0 = {7'h00, !xtal};
            @(negedge mclk);
            chk("crystal out", v0, {7'h00, crystal_output_pin});
        end
        wrap_up;
    end
endmodule
